// ==== inc/periph_consts.vh ====
// Purpose: Constants for the core peripheral register block
// Assumes: 16-bit core data bus, word addresses in hardware register space
// Notes:   Offsets are full core data addresses
`ifndef PERIPH_CONSTS_VH
`define PERIPH_CONSTS_VH
// ****************************************************************
// Register addresses
// ****************************************************************
`define ADDR_SERIAL_INPUT_WORD    16'hC011
`define ADDR_REQUEST_PIN_CONTROL  16'hC012
`define ADDR_SAMPLE_RATE_LOW      16'hC013
`define ADDR_SAMPLE_RATE_HIGH_PLL 16'hC014
`define ADDR_PCM_LEFT_SAMPLE      16'hC015
`define ADDR_PCM_RIGHT_SAMPLE     16'hC016
`define ADDR_PIN_DIRECTION        16'hC017
`define ADDR_PIN_INPUT_LEVELS     16'hC018
`define ADDR_PIN_OUTPUT_LEVELS    16'hC019
`define ADDR_IRQ_SOURCE_MASK      16'hC01A
`define ADDR_IRQ_NEST_INCREMENT   16'hC01B
`define ADDR_IRQ_NEST_DECREMENT   16'hC01C
`define ADDR_IRQ_NEST_LEVEL       16'hC01D
`define ADDR_ADC_RATE_DIVIDER     16'hC01E
`define ADDR_ADC_RESULT           16'hC01F
// ****************************************************************
// Field layouts and timing
// ****************************************************************
`define RATE_HIGH_BITS            4
`define ACC_WIDTH                 26
`define ACC_STEP_CYCLES           2'h3
`define ADC_CYCLES_PER_UNIT       7
`define IRQ_LATENCY_STAGES        6
`define NEST_WIDTH                5
`define IRQ_SOURCES               8
`define IRQ_BIT_DAC               0
`define IRQ_BIT_MODULATOR         3
`define IRQ_BIT_SERIAL_DATA       2
`define IRQ_BIT_SERIAL_CONTROL    1
`endif

// ==== rtl/rate_accumulator.v ====
// Purpose: Sample-rate phase accumulator feeding the DAC
// Assumes: Step value is static relative to the four-cycle cadence
// Notes:   Overflow pulse is one cycle wide
`include "periph_consts.vh"
module rate_accumulator (
   // Clock and reset
   input  wire        clk_sys_i,
   input  wire        rst_n_i,
   input  wire        clk_en_i,
   // Step value
   input  wire [19:0] step_i,
   // Overflow
   output reg         overflow_o
);
   reg [1:0]                phase_q;
   reg [`ACC_WIDTH-1:0]     acc_q;
   wire [`ACC_WIDTH:0]      sum;
   assign sum = {1'b0, acc_q} + {7'h00, step_i};
   // ****************************************************************
   // Add every fourth cycle, flag the carry out
   // ****************************************************************
   always @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         phase_q    <= 2'h0;
         acc_q      <= 26'h0000000;
         overflow_o <= 1'b0;
      end else if (clk_en_i) begin
         phase_q    <= phase_q + 2'h1;
         overflow_o <= 1'b0;
         if (phase_q == `ACC_STEP_CYCLES) begin
            acc_q      <= sum[`ACC_WIDTH-1:0];
            overflow_o <= sum[`ACC_WIDTH];
         end
      end
   end
endmodule

// ==== rtl/adc_pacer.v ====
// Purpose: Pacing of A/D modulator samples from the divider value
// Assumes: Divider changes apply to the running count without restarting the sample period
// Notes:   Divider zero stops the converter
`include "periph_consts.vh"
module adc_pacer (
   // Clock and reset
   input  wire        clk_sys_i,
   input  wire        rst_n_i,
   input  wire        clk_en_i,
   // Divider
   input  wire [15:0] divider_i,
   // Sample done
   output reg         sample_done_o
);
   reg  [22:0] count_q;
   wire [22:0] period;
   assign period = {divider_i, 7'h00};
   // ****************************************************************
   // Count 128 times divider cycles per sample
   // ****************************************************************
   always @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         count_q       <= 23'h000000;
         sample_done_o <= 1'b0;
      end else if (clk_en_i) begin
         sample_done_o <= 1'b0;
         if (divider_i == 16'h0000) begin
            count_q <= 23'h000000;
         end else if (count_q >= period - 23'h000001) begin
            count_q       <= 23'h000000;
            sample_done_o <= 1'b1;
         end else begin
            count_q <= count_q + 23'h000001;
         end
      end
   end
endmodule

// ==== rtl/dsp_peripheral_regs.v ====
// Purpose: Core peripheral registers: interrupt nesting, DAC rate, GPIO, serial data, A/D
// Assumes: Single-cycle core data bus, host window access arrives as core-side bus cycles
// Notes:   Interrupt sources outside this block enter as pulses on irq_src_i
//
// Functional notes
// - Serial word packs last two bytes, earlier high
// - Add frequency word to accumulator every fourth cycle
// - Overflow fetches PCM samples, raises DAC source
// - High rate register also holds PLL control
// - Direction bit one makes pin output
// - Output values kept when switched to input
// - Input register reads live pin levels
// - Pins never cause interrupts
// - Enable mask bits gate the eight sources
// - Mask changes act within six cycles
// - Write to increment register raises nesting
// - Write to decrement lowers nesting, floor zero
// - Nesting zero restores masked interrupts
// - Taken interrupt increments nesting counter
// - Nesting writes act within six cycles
// - Nesting counter readable, writable, nonzero blocks
// - Sample takes 128 times divider cycles
// - Divider zero turns converter off
// - Result register holds latest conversion
// - Host reaches registers via window pointer
// - Enable mask sits at 0xC01A
`include "periph_consts.vh"
module dsp_peripheral_regs (
   // Clock, enable and reset
   input  wire        clk_sys_i,
   input  wire        rst_n_i,
   input  wire        clk_en_i,
   // Core data bus
   input  wire [15:0] bus_addr_i,
   input  wire [15:0] bus_wdata_i,
   input  wire        bus_wr_i,
   input  wire        bus_rd_i,
   output reg  [15:0] bus_rdata_o,
   // Interrupt to core
   input  wire [7:0]  irq_src_i,
   input  wire        irq_ack_i,
   output reg         irq_req_o,
   output reg  [2:0]  irq_vector_o,
   // Serial data receive
   input  wire [7:0]  serial_byte_i,
   input  wire        serial_byte_valid_i,
   output reg         data_request_pin_o,
   // DAC
   output reg  [15:0] dac_left_o,
   output reg  [15:0] dac_right_o,
   output reg         dac_load_o,
   output reg  [11:0] pll_control_o,
   // A/D modulator
   input  wire [15:0] adc_decoded_i,
   output reg         adc_enable_o,
   // General-purpose pins
   input  wire [3:0]  gpio_in_i,
   output reg  [3:0]  gpio_out_o,
   output reg  [3:0]  gpio_oe_o
);
   // ****************************************************************
   // Registers
   // ****************************************************************
   reg [15:0]             serial_input_word_q;
   reg [15:0]             sample_rate_low_q;
   reg [15:0]             sample_rate_high_pll_q;
   reg [15:0]             pcm_left_sample_q;
   reg [15:0]             pcm_right_sample_q;
   reg [3:0]              pin_direction_q;
   reg [3:0]              pin_output_levels_q;
   reg [`IRQ_SOURCES-1:0] irq_source_mask_q;
   reg [`NEST_WIDTH-1:0]  irq_nest_level_q;
   reg [15:0]             adc_rate_divider_q;
   reg [15:0]             adc_result_q;
   reg [`IRQ_SOURCES-1:0] pending_q;
   reg [`IRQ_SOURCES-1:0] mask_pipe_q [0:`IRQ_LATENCY_STAGES-2];
   reg [`IRQ_SOURCES-1:0] mask_eff_q;
   reg [`IRQ_LATENCY_STAGES-2:0] inc_pipe_q;
   reg [`IRQ_LATENCY_STAGES-2:0] dec_pipe_q;
   wire                   acc_overflow;
   wire                   adc_sample_done;
   wire [`IRQ_SOURCES-1:0] src_all;
   wire [`IRQ_SOURCES-1:0] active;
   wire                   nest_inc;
   wire                   nest_dec;
   wire                   wr_nest_level;
   wire                   take;
   reg  [2:0]             pick;
   integer                k, j;

   // ****************************************************************
   // Sub-blocks
   // ****************************************************************
   rate_accumulator u_rate (
      .clk_sys_i  (clk_sys_i),
      .rst_n_i    (rst_n_i),
      .clk_en_i   (clk_en_i),
      .step_i     ({sample_rate_high_pll_q[`RATE_HIGH_BITS-1:0], sample_rate_low_q}),
      .overflow_o (acc_overflow)
   );

   adc_pacer u_adc (
      .clk_sys_i     (clk_sys_i),
      .rst_n_i       (rst_n_i),
      .clk_en_i      (clk_en_i),
      .divider_i     (adc_rate_divider_q),
      .sample_done_o (adc_sample_done)
   );

   // Pins add no source
   assign src_all = irq_src_i
                    | ({7'h00, acc_overflow} << `IRQ_BIT_DAC)
                    | ({7'h00, adc_sample_done} << `IRQ_BIT_MODULATOR)
                    | ({7'h00, serial_byte_valid_i} << `IRQ_BIT_SERIAL_DATA);

   // ****************************************************************
   // Bus writes to plain registers
   // ****************************************************************
   always @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sample_rate_low_q      <= 16'h0000;
         sample_rate_high_pll_q <= 16'h0000;
         pcm_left_sample_q      <= 16'h0000;
         pcm_right_sample_q     <= 16'h0000;
         pin_direction_q        <= 4'h0;
         pin_output_levels_q    <= 4'h0;
         irq_source_mask_q      <= 8'h00;
         adc_rate_divider_q     <= 16'h0000;
         data_request_pin_o     <= 1'b0;
      end else if (clk_en_i && bus_wr_i) begin
         case (bus_addr_i)
            `ADDR_REQUEST_PIN_CONTROL:  data_request_pin_o <= bus_wdata_i[0];
            `ADDR_SAMPLE_RATE_LOW:      sample_rate_low_q <= bus_wdata_i;
            `ADDR_SAMPLE_RATE_HIGH_PLL: sample_rate_high_pll_q <= bus_wdata_i;
            `ADDR_PCM_LEFT_SAMPLE:      pcm_left_sample_q <= bus_wdata_i;
            `ADDR_PCM_RIGHT_SAMPLE:     pcm_right_sample_q <= bus_wdata_i;
            `ADDR_PIN_DIRECTION:        pin_direction_q <= bus_wdata_i[3:0];
            `ADDR_PIN_OUTPUT_LEVELS:    pin_output_levels_q <= bus_wdata_i[3:0];
            `ADDR_IRQ_SOURCE_MASK:      irq_source_mask_q <= bus_wdata_i[7:0];
            `ADDR_ADC_RATE_DIVIDER:     adc_rate_divider_q <= bus_wdata_i;
            default: ;
         endcase
      end
   end

   // ****************************************************************
   // Serial byte packing and A/D result capture
   // ****************************************************************
   always @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         serial_input_word_q <= 16'h0000;
         adc_result_q        <= 16'h0000;
      end else if (clk_en_i) begin
         if (serial_byte_valid_i) begin
            serial_input_word_q <= {serial_input_word_q[7:0], serial_byte_i};
         end
         if (adc_sample_done) begin
            adc_result_q <= adc_decoded_i;
         end else if (bus_wr_i && bus_addr_i == `ADDR_ADC_RESULT) begin
            adc_result_q <= bus_wdata_i;
         end
      end
   end

   // ****************************************************************
   // DAC sample fetch, PLL, A/D enable and pin drive
   // ****************************************************************
   always @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         dac_left_o    <= 16'h0000;
         dac_right_o   <= 16'h0000;
         dac_load_o    <= 1'b0;
         pll_control_o <= 12'h000;
         adc_enable_o  <= 1'b0;
         gpio_out_o    <= 4'h0;
         gpio_oe_o     <= 4'h0;
      end else if (clk_en_i) begin
         dac_load_o    <= acc_overflow;
         if (acc_overflow) begin
            dac_left_o  <= pcm_left_sample_q;
            dac_right_o <= pcm_right_sample_q;
         end
         pll_control_o <= sample_rate_high_pll_q[15:`RATE_HIGH_BITS];
         adc_enable_o  <= (adc_rate_divider_q != 16'h0000);
         gpio_out_o    <= pin_output_levels_q;
         gpio_oe_o     <= pin_direction_q;
      end
   end

   // ****************************************************************
   // Write latency pipelines for mask and nesting writes
   // ****************************************************************
   assign nest_inc = inc_pipe_q[`IRQ_LATENCY_STAGES-2];
   assign nest_dec = dec_pipe_q[`IRQ_LATENCY_STAGES-2];

   always @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         for (k = 0; k < `IRQ_LATENCY_STAGES-1; k = k + 1) begin
            mask_pipe_q[k] <= 8'h00;
         end
         mask_eff_q <= 8'h00;
         inc_pipe_q <= 5'h00;
         dec_pipe_q <= 5'h00;
      end else if (clk_en_i) begin
         mask_pipe_q[0] <= irq_source_mask_q;
         for (k = 1; k < `IRQ_LATENCY_STAGES-1; k = k + 1) begin
            mask_pipe_q[k] <= mask_pipe_q[k-1];
         end
         mask_eff_q <= mask_pipe_q[`IRQ_LATENCY_STAGES-2];
         inc_pipe_q <= {inc_pipe_q[`IRQ_LATENCY_STAGES-3:0],
                        bus_wr_i && bus_addr_i == `ADDR_IRQ_NEST_INCREMENT};
         dec_pipe_q <= {dec_pipe_q[`IRQ_LATENCY_STAGES-3:0],
                        bus_wr_i && bus_addr_i == `ADDR_IRQ_NEST_DECREMENT};
      end
   end

   // ****************************************************************
   // Nesting counter
   // ****************************************************************
   assign wr_nest_level = bus_wr_i && bus_addr_i == `ADDR_IRQ_NEST_LEVEL;
   assign take          = irq_req_o && irq_ack_i;

   always @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         irq_nest_level_q <= 5'h00;
      end else if (clk_en_i) begin
         if (wr_nest_level) begin
            irq_nest_level_q <= bus_wdata_i[`NEST_WIDTH-1:0];
         end else begin
            // Increments and decrements in one cycle cancel out
            case ({take | nest_inc, nest_dec})
               2'h2: irq_nest_level_q <= irq_nest_level_q + 5'h01;
               2'h1: if (irq_nest_level_q != 5'h00) begin
                  irq_nest_level_q <= irq_nest_level_q - 5'h01;
               end
               2'h3: if (take && nest_inc) begin
                  irq_nest_level_q <= irq_nest_level_q + 5'h01;
               end
               default: ;
            endcase
         end
      end
   end

   // ****************************************************************
   // Pending sources and request
   // ****************************************************************
   assign active = pending_q & mask_eff_q;

   // Lowest enabled pending source wins
   always @* begin
      pick = 3'h0;
      for (j = `IRQ_SOURCES-1; j >= 0; j = j - 1) begin
         if (active[j]) begin
            pick = j[2:0];
         end
      end
   end

   genvar g;
   generate
      for (g = 0; g < `IRQ_SOURCES; g = g + 1) begin : g_pend
         always @(posedge clk_sys_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
               pending_q[g] <= 1'b0;
            end else if (clk_en_i) begin
               // A new event wins over the acknowledge clear
               if (src_all[g]) begin
                  pending_q[g] <= 1'b1;
               end else if (take && irq_vector_o == g) begin
                  pending_q[g] <= 1'b0;
               end
            end
         end
      end
   endgenerate

   always @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         irq_req_o    <= 1'b0;
         irq_vector_o <= 3'h0;
      end else if (clk_en_i) begin
         if (take) begin
            irq_req_o <= 1'b0;
         end else begin
            irq_req_o    <= (|active) && (irq_nest_level_q == 5'h00);
            irq_vector_o <= pick;
         end
      end
   end

   // ****************************************************************
   // Read mux, also serves host window accesses
   // ****************************************************************
   always @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         bus_rdata_o <= 16'h0000;
      end else if (clk_en_i && bus_rd_i) begin
         case (bus_addr_i)
            `ADDR_SERIAL_INPUT_WORD:    bus_rdata_o <= serial_input_word_q;
            `ADDR_SAMPLE_RATE_LOW:      bus_rdata_o <= sample_rate_low_q;
            `ADDR_SAMPLE_RATE_HIGH_PLL: bus_rdata_o <= sample_rate_high_pll_q;
            `ADDR_PCM_LEFT_SAMPLE:      bus_rdata_o <= pcm_left_sample_q;
            `ADDR_PCM_RIGHT_SAMPLE:     bus_rdata_o <= pcm_right_sample_q;
            `ADDR_PIN_DIRECTION:        bus_rdata_o <= {12'h000, pin_direction_q};
            `ADDR_PIN_INPUT_LEVELS:     bus_rdata_o <= {12'h000, gpio_in_i};
            `ADDR_PIN_OUTPUT_LEVELS:    bus_rdata_o <= {12'h000, pin_output_levels_q};
            `ADDR_IRQ_SOURCE_MASK:      bus_rdata_o <= {8'h00, irq_source_mask_q};
            `ADDR_IRQ_NEST_LEVEL:       bus_rdata_o <= {11'h000, irq_nest_level_q};
            `ADDR_ADC_RATE_DIVIDER:     bus_rdata_o <= adc_rate_divider_q;
            `ADDR_ADC_RESULT:           bus_rdata_o <= adc_result_q;
            default:                    bus_rdata_o <= 16'h0000;
         endcase
      end
   end
endmodule

// ==== verification/periph_props.sv ====
// Purpose: Port checker for the peripheral register block
// Assumes: Bus cycles spaced by at least one idle cycle
// Notes:   Bound to every dsp_peripheral_regs instance
`include "periph_consts.vh"
module periph_props (
   // Clock and reset
   input wire        clk_sys_i,
   input wire        rst_n_i,
   input wire        clk_en_i,
   // Core data bus
   input wire [15:0] bus_addr_i,
   input wire [15:0] bus_wdata_i,
   input wire        bus_wr_i,
   input wire        bus_rd_i,
   input wire [15:0] bus_rdata_o,
   // Watched outputs, acknowledge and pin inputs
   input wire        irq_ack_i,
   input wire        irq_req_o,
   input wire [3:0]  gpio_in_i,
   input wire [3:0]  gpio_out_o,
   input wire [3:0]  gpio_oe_o,
   input wire        dac_load_o,
   input wire [11:0] pll_control_o,
   input wire        adc_enable_o
);
   // ****************
   // Properties
   // ****************
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);
   sequence wr_at(a); clk_en_i && bus_wr_i && bus_addr_i == a; endsequence
   sequence rd_at(a); clk_en_i && bus_rd_i && bus_addr_i == a; endsequence
   sequence mask_wr_rd; wr_at(`ADDR_IRQ_SOURCE_MASK) ##2 rd_at(`ADDR_IRQ_SOURCE_MASK); endsequence
   oe_follow_a: assert property (wr_at(`ADDR_PIN_DIRECTION) |=> ##1
      gpio_oe_o == $past(bus_wdata_i[3:0], 2)) else $error("pin enables differ from direction");
   out_keep_a: assert property (wr_at(`ADDR_PIN_DIRECTION) |=> ##1
      gpio_out_o == $past(gpio_out_o, 2)) else $error("pin outputs moved on direction write");
   pin_read_a: assert property (rd_at(`ADDR_PIN_INPUT_LEVELS) |=>
      bus_rdata_o == {12'h000, $past(gpio_in_i)}) else $error("pin level read wrong");
   pll_field_a: assert property (wr_at(`ADDR_SAMPLE_RATE_HIGH_PLL) |=> ##1
      pll_control_o == $past(bus_wdata_i[15:4], 2)) else $error("pll control wrong");
   adc_enable_a: assert property (wr_at(`ADDR_ADC_RATE_DIVIDER) |=> ##1
      adc_enable_o == ($past(bus_wdata_i, 2) != 16'h0000)) else $error("converter enable wrong");
   mask_read_a: assert property (mask_wr_rd |=>
      bus_rdata_o == {8'h00, $past(bus_wdata_i[7:0], 3)}) else $error("mask readback wrong");
   ack_drop_a: assert property (irq_req_o && irq_ack_i |=>
      !irq_req_o ##1 !irq_req_o) else $error("request held after being taken");
   load_pulse_a: assert property (dac_load_o |=> (!dac_load_o) [*8])
      else $error("sample loads too close together");
endmodule
bind dsp_peripheral_regs periph_props u_props (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en_i),
   .bus_addr_i(bus_addr_i), .bus_wdata_i(bus_wdata_i), .bus_wr_i(bus_wr_i), .bus_rd_i(bus_rd_i),
   .bus_rdata_o(bus_rdata_o), .irq_ack_i(irq_ack_i), .irq_req_o(irq_req_o), .gpio_in_i(gpio_in_i),
   .gpio_out_o(gpio_out_o), .gpio_oe_o(gpio_oe_o), .dac_load_o(dac_load_o),
   .pll_control_o(pll_control_o), .adc_enable_o(adc_enable_o));

// ==== verification/core_model.sv ====
// Purpose: Core side that takes interrupt requests
// Assumes: Acknowledge is one cycle, sampled with the request
// Notes:   slow_i adds three cycles of service latency
module core_model (
   // Clock and reset
   input  wire       clk_sys_i,
   input  wire       rst_n_i,
   // Interrupt handshake
   input  wire       req_i,
   input  wire       slow_i,
   output logic      ack_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] wait_q;
   // Take the request after a short or long delay
   always @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ack_o  <= 1'b0;
         wait_q <= 2'h0;
      end else if (ack_o || !req_i) begin
         ack_o  <= 1'b0;
         wait_q <= 2'h0;
      end else if (wait_q == (slow_i ? 2'h3 : 2'h0)) begin
         ack_o  <= 1'b1;
      end else begin
         wait_q <= wait_q + 2'h1;
      end
   end
endmodule

// ==== verification/tb_top.sv ====
// Purpose: Self-checking bench for the peripheral register block
// Assumes: Clock enable held high
// Notes:   Random data from a fixed seed
`include "periph_consts.vh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk_sys_i, rst_n_i, bus_wr_i, bus_rd_i, irq_ack_i, serial_byte_valid_i, slow_q;
   logic        irq_req_o, data_request_pin_o, dac_load_o, adc_enable_o;
   logic [2:0]  irq_vector_o;
   logic [3:0]  gpio_in_i, gpio_out_o, gpio_oe_o;
   logic [7:0]  irq_src_i, serial_byte_i;
   logic [11:0] pll_control_o;
   logic [15:0] bus_addr_i, bus_wdata_i, bus_rdata_o, dac_left_o, dac_right_o, adc_decoded_i, v, w;
   int          mismatches = 0, checked = 0, n, seed_q;
   dsp_peripheral_regs u_dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .clk_en_i(1'b1),
      .bus_addr_i(bus_addr_i), .bus_wdata_i(bus_wdata_i), .bus_wr_i(bus_wr_i), .bus_rd_i(bus_rd_i),
      .bus_rdata_o(bus_rdata_o), .irq_src_i(irq_src_i), .irq_ack_i(irq_ack_i), .irq_req_o(irq_req_o),
      .irq_vector_o(irq_vector_o), .serial_byte_i(serial_byte_i), .serial_byte_valid_i(serial_byte_valid_i),
      .data_request_pin_o(data_request_pin_o), .dac_left_o(dac_left_o), .dac_right_o(dac_right_o),
      .dac_load_o(dac_load_o), .pll_control_o(pll_control_o), .adc_decoded_i(adc_decoded_i),
      .adc_enable_o(adc_enable_o), .gpio_in_i(gpio_in_i), .gpio_out_o(gpio_out_o), .gpio_oe_o(gpio_oe_o));
   core_model u_core (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .req_i(irq_req_o), .slow_i(slow_q),
      .ack_o(irq_ack_i));
   // ****************
   // Helpers
   // ****************
   task automatic chk_data(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_flag(input logic got, input logic exp);
      chk_data({15'h0000, got}, {15'h0000, exp});
   endtask
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge clk_sys_i);
      bus_wr_i    <= 1'b1;
      bus_addr_i  <= a;
      bus_wdata_i <= d;
      @(posedge clk_sys_i);
      bus_wr_i    <= 1'b0;
   endtask
   task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp);
      @(posedge clk_sys_i);
      bus_rd_i   <= 1'b1;
      bus_addr_i <= a;
      @(posedge clk_sys_i);
      bus_rd_i   <= 1'b0;
      #1 chk_data(bus_rdata_o, exp);
   endtask
   task automatic settle(input int c);
      repeat (c) @(posedge clk_sys_i);
      #1;
   endtask
   task automatic pulse(input int i);
      @(posedge clk_sys_i);
      irq_src_i <= 8'h01 << i;
      @(posedge clk_sys_i);
      irq_src_i <= 8'h00;
   endtask
   // Bounded wait for request
   task automatic wait_req(input logic lvl);
      #1 n = 0;
      while (irq_req_o !== lvl && n < 14) begin
         @(posedge clk_sys_i);
         #1 n++;
      end
   endtask
   // Cycles to next sample load
   task automatic wait_load;
      n = 0;
      do begin
         @(posedge clk_sys_i);
         #1 n++;
      end while (dac_load_o !== 1'b1 && n < 1000);
   endtask
   task automatic tally_and_finish;
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // Clock and watchdog
   initial begin
      clk_sys_i = 1'b0;
      forever #50 clk_sys_i = ~clk_sys_i;
   end
   initial begin
      repeat (20000) @(posedge clk_sys_i);
      mismatches++;
      tally_and_finish;
   end
   // ****************
   // Tests
   // ****************
   initial begin
      {rst_n_i, bus_wr_i, bus_rd_i, serial_byte_valid_i, slow_q, irq_src_i, serial_byte_i, gpio_in_i} = '0;
      {bus_addr_i, bus_wdata_i, adc_decoded_i} = '0;
      seed_q = $urandom(32'h8581);
      repeat (8) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      for (logic [15:0] a = 16'hC011; a <= 16'hC020; a++)
         if (!(a inside {16'hC012, 16'hC01B, 16'hC01C})) rd_chk(a, 16'h0000);
      $display("test reset values done");
      for (int i = 0; i < 8; i++) begin
         slow_q <= i[0];
         wr(`ADDR_IRQ_SOURCE_MASK, 16'h0001 << i);
         rd_chk(`ADDR_IRQ_SOURCE_MASK, 16'h0001 << i);
         pulse(i);
         wait_req(1'b1);
         chk_flag(irq_req_o, 1'b1);
         chk_data({13'h0000, irq_vector_o}, 16'(i));
         wait_req(1'b0);
         rd_chk(`ADDR_IRQ_NEST_LEVEL, 16'h0001);
         wr(`ADDR_IRQ_NEST_DECREMENT, 16'($urandom));
         settle(7);
         rd_chk(`ADDR_IRQ_NEST_LEVEL, 16'h0000);
      end
      wr(`ADDR_IRQ_NEST_INCREMENT, 16'h1234);
      wr(`ADDR_IRQ_NEST_INCREMENT, 16'h0000);
      wr(`ADDR_IRQ_SOURCE_MASK, 16'h00FF);
      settle(7);
      pulse(5);
      settle(14);
      chk_flag(irq_req_o, 1'b0);
      rd_chk(`ADDR_IRQ_NEST_LEVEL, 16'h0002);
      wr(`ADDR_IRQ_NEST_DECREMENT, 16'h0000);
      settle(14);
      chk_flag(irq_req_o, 1'b0);
      wr(`ADDR_IRQ_NEST_DECREMENT, 16'h0000);
      wait_req(1'b1);
      chk_data({13'h0000, irq_vector_o}, 16'h0005);
      wait_req(1'b0);
      wr(`ADDR_IRQ_NEST_DECREMENT, 16'h0000);
      wr(`ADDR_IRQ_NEST_DECREMENT, 16'h0000);
      wr(`ADDR_IRQ_SOURCE_MASK, 16'h0000);
      settle(7);
      rd_chk(`ADDR_IRQ_NEST_LEVEL, 16'h0000);
      pulse(6);
      settle(14);
      chk_flag(irq_req_o, 1'b0);
      wr(`ADDR_IRQ_NEST_LEVEL, 16'h0013);
      rd_chk(`ADDR_IRQ_NEST_LEVEL, 16'h0013);
      wr(`ADDR_IRQ_NEST_LEVEL, 16'h0000);
      wr(`ADDR_IRQ_SOURCE_MASK, 16'h0040);
      wait_req(1'b1);
      chk_flag(irq_req_o, 1'b1);
      wait_req(1'b0);
      wr(`ADDR_IRQ_NEST_DECREMENT, 16'h0000);
      $display("test interrupt nesting done");
      repeat (4) begin
         v = 16'($urandom);
         @(posedge clk_sys_i);
         gpio_in_i <= v[11:8];
         wr(`ADDR_PIN_DIRECTION, {12'h000, v[3:0]});
         wr(`ADDR_PIN_OUTPUT_LEVELS, {12'h000, v[7:4]});
         settle(2);
         chk_data({12'h000, gpio_oe_o}, {12'h000, v[3:0]});
         rd_chk(`ADDR_PIN_INPUT_LEVELS, {12'h000, v[11:8]});
         wr(`ADDR_PIN_DIRECTION, 16'h0000);
         wr(`ADDR_PIN_INPUT_LEVELS, 16'hFFFF);
         wr(`ADDR_REQUEST_PIN_CONTROL, v);
         settle(2);
         chk_data({12'h000, gpio_out_o}, {12'h000, v[7:4]});
         chk_flag(data_request_pin_o, v[0]);
         rd_chk(`ADDR_PIN_INPUT_LEVELS, {12'h000, v[11:8]});
      end
      chk_flag(irq_req_o, 1'b0);
      $display("test pins done");
      w = 16'h0000;
      repeat (3) begin
         v = 16'($urandom);
         @(posedge clk_sys_i);
         serial_byte_i       <= v[7:0];
         serial_byte_valid_i <= 1'b1;
         @(posedge clk_sys_i);
         serial_byte_valid_i <= 1'b0;
         w = {w[7:0], v[7:0]};
         rd_chk(`ADDR_SERIAL_INPUT_WORD, w);
      end
      $display("test serial word done");
      v = 16'($urandom);
      w = 16'($urandom);
      wr(`ADDR_PCM_LEFT_SAMPLE, v);
      wr(`ADDR_PCM_RIGHT_SAMPLE, w);
      wr(`ADDR_SAMPLE_RATE_HIGH_PLL, {v[11:0], 4'h8});
      settle(2);
      chk_data({4'h0, pll_control_o}, {4'h0, v[11:0]});
      wait_load;
      chk_flag(dac_load_o, 1'b1);
      chk_data(dac_right_o, w);
      chk_data(dac_left_o, v);
      wait_load;
      chk_data(16'(n), 16'h0200);
      wr(`ADDR_SAMPLE_RATE_HIGH_PLL, 16'h0000);
      $display("test sample rate done");
      v = 16'($urandom);
      w = ~v;
      @(posedge clk_sys_i);
      adc_decoded_i <= v;
      wr(`ADDR_ADC_RATE_DIVIDER, 16'h0004);
      settle(600);
      rd_chk(`ADDR_ADC_RESULT, v);
      adc_decoded_i <= w;
      settle(600);
      rd_chk(`ADDR_ADC_RESULT, w);
      wr(`ADDR_ADC_RATE_DIVIDER, 16'h0000);
      adc_decoded_i <= v;
      settle(600);
      chk_flag(adc_enable_o, 1'b0);
      rd_chk(`ADDR_ADC_RESULT, w);
      $display("test converter done");
      tally_and_finish;
   end
endmodule
